// ### logic/atss_pkg.sv
// Package for the converter trigger-source selector: offsets, field layout, codes.
// Assumes a 32-bit APB register bus with byte addresses.
package atss_pkg;
   localparam int ATSS_ADDR_W = 12;
   localparam int ATSS_NUM_SEQ = 4;
   localparam int ATSS_CODE_W = 4;
   localparam logic [11:0] ATSS_TRIG_SEL_OFFSET = 12'h014;
   localparam logic [31:0] ATSS_TRIG_SEL_RESET = 32'h0000_0000;
   localparam int ATSS_FIELD_USED_W = 16;
   localparam logic [3:0] ATSS_CODE_SOFTWARE = 4'h0;
   localparam logic [3:0] ATSS_CODE_COMPARATOR = 4'h1;
   localparam logic [3:0] ATSS_CODE_EXTERNAL = 4'h4;
   localparam logic [3:0] ATSS_CODE_TIMER = 4'h5;
   localparam logic [3:0] ATSS_CODE_ALWAYS = 4'hf;
   localparam int ATSS_PIN_SYNC_STAGES = 3;
endpackage

// ### logic/atss_trigger_select.sv
// Trigger-source selector for four sample sequencers, with its APB register.
// Assumes event inputs from same-clock logic except the external pin, which is asynchronous.
`timescale 1ns/100ps

module atss_trigger_select (
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [3:0] SOFTWARE_REQUEST,
   input wire logic COMPARATOR0_EVENT,
   input wire logic EXTERNAL_TRIGGER_PIN,
   input wire logic TIMER_EVENT,
   input wire logic TIMER_ADC_TRIGGER_ENABLE,
   output logic [3:0] SEQ_START,
   output logic [15:0] SEQUENCER_TRIGGER_SELECT
);

   // ----------------------------------------------------------------
   // Register access
   // ----------------------------------------------------------------
   logic [15:0] trig_sel;
   logic hit;
   logic wr_en;

   assign hit = (PADDR == atss_pkg::ATSS_TRIG_SEL_OFFSET);
   assign wr_en = PSEL && PENABLE && PWRITE && hit;
   // Zero-wait slave; unmapped addresses read zero without error
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         trig_sel <= atss_pkg::ATSS_TRIG_SEL_RESET[15:0];
      end else if (wr_en) begin
         if (PSTRB[0]) begin
            trig_sel[7:0] <= PWDATA[7:0];
         end
         if (PSTRB[1]) begin
            trig_sel[15:8] <= PWDATA[15:8];
         end
      end
   end

   // Read data is combinational over stable APB signals, so it is valid in the access phase
   always_comb begin
      PRDATA = 32'h0000_0000;
      if (PSEL && !PWRITE && hit) begin
         PRDATA = {16'h0000, trig_sel};
      end
   end

   assign SEQUENCER_TRIGGER_SELECT = trig_sel;

   // ----------------------------------------------------------------
   // External pin synchroniser
   // ----------------------------------------------------------------
   logic [2:0] pin_sync;
   logic pin_level;

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         pin_sync <= 3'h0;
      end else begin
         pin_sync <= {pin_sync[1:0], EXTERNAL_TRIGGER_PIN};
      end
   end

   // Level changes only once stages two and three agree; filters single-cycle glitches
   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         pin_level <= 1'b0;
      end else if (pin_sync[1] == pin_sync[2]) begin
         pin_level <= pin_sync[2];
      end
   end

   // ----------------------------------------------------------------
   // Per-sequencer event selection
   // ----------------------------------------------------------------
   logic [3:0] next_start;

   // Each sequencer decodes its own field into a private pick bit, so one
   // process never writes a bit that another process also writes
   genvar g;
   generate
      for (g = 0; g < atss_pkg::ATSS_NUM_SEQ; g++) begin : g_seq
         logic [3:0] code;
         logic pick;
         assign code = trig_sel[4*g+3:4*g];
         always_comb begin
            case (code)
               atss_pkg::ATSS_CODE_SOFTWARE: pick = SOFTWARE_REQUEST[g];
               atss_pkg::ATSS_CODE_COMPARATOR: pick = COMPARATOR0_EVENT;
               atss_pkg::ATSS_CODE_EXTERNAL: pick = pin_level;
               atss_pkg::ATSS_CODE_TIMER: pick = TIMER_EVENT && TIMER_ADC_TRIGGER_ENABLE;
               atss_pkg::ATSS_CODE_ALWAYS: pick = 1'b1;
               default: pick = 1'b0;
            endcase
         end
         assign next_start[g] = pick;
      end
   endgenerate

   always_ff @(posedge MCLK) begin
      if (!RESET_N) begin
         SEQ_START <= 4'h0;
      end else begin
         SEQ_START <= next_start;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   // ----------------------------------------------------------------
   // Register field checks
   // ----------------------------------------------------------------
   write_seq2_a: assert property (wr_en && PSTRB[1]
      |=> trig_sel[11:8] == $past(PWDATA[11:8]))
      else $error("sequencer 2 field not written");
   write_seq1_a: assert property (wr_en && PSTRB[0]
      |=> trig_sel[7:4] == $past(PWDATA[7:4]))
      else $error("sequencer 1 field not written");
   write_seq0_a: assert property (wr_en && PSTRB[0]
      |=> trig_sel[3:0] == $past(PWDATA[3:0]))
      else $error("sequencer 0 field not written");
   write_seq3_a: assert property (wr_en && PSTRB[1]
      |=> trig_sel[15:12] == $past(PWDATA[15:12]))
      else $error("sequencer 3 field not written");
   lane_low_keep_a: assert property (wr_en && !PSTRB[0]
      |=> trig_sel[7:0] == $past(trig_sel[7:0]))
      else $error("low byte changed without its strobe");
   lane_high_keep_a: assert property (wr_en && !PSTRB[1]
      |=> trig_sel[15:8] == $past(trig_sel[15:8]))
      else $error("high byte changed without its strobe");
   idle_hold_a: assert property (!wr_en
      |=> $stable(trig_sel))
      else $error("select register changed without a write");
   reset_value_a: assert property (!$past(RESET_N)
      |-> trig_sel == 16'h0000)
      else $error("select register not zero after reset");
   read_back_a: assert property (PSEL && PENABLE && !PWRITE && hit
      |-> PRDATA == {16'h0000, trig_sel})
      else $error("read data mismatch");
   read_idle_a: assert property (!(PSEL && !PWRITE && hit)
      |-> PRDATA == 32'h0000_0000)
      else $error("read data not zero off the register");
   mirror_a: assert property (1'b1
      |-> SEQUENCER_TRIGGER_SELECT == trig_sel)
      else $error("select output differs from the register");
   ready_a: assert property (PSEL && PENABLE
      |-> PREADY && !PSLVERR)
      else $error("bus answer not ready without error");

   // ----------------------------------------------------------------
   // Start path checks
   // ----------------------------------------------------------------
   start_reset_a: assert property (!$past(RESET_N)
      |-> SEQ_START == 4'h0)
      else $error("start outputs not zero after reset");
   always_start_a: assert property (trig_sel[3:0] == 4'hf
      |=> SEQ_START[0])
      else $error("continuous mode did not start sequencer 0");
   soft_start_a: assert property (trig_sel[7:4] == 4'h0
      |=> SEQ_START[1] == $past(SOFTWARE_REQUEST[1]))
      else $error("software request not routed to sequencer 1");
   timer_gate_a: assert property (trig_sel[11:8] == 4'h5 && !TIMER_ADC_TRIGGER_ENABLE
      |=> !SEQ_START[2])
      else $error("timer triggered without enable");
   reserved_code_a: assert property (trig_sel[15:12] inside {4'h2, 4'h3, [4'h6:4'he]}
      |=> !SEQ_START[3])
      else $error("reserved code produced a trigger");
   pin_filter_a: assert property (pin_sync[1] != pin_sync[2]
      |=> $stable(pin_level))
      else $error("pin level moved while stages disagree");
   pin_follow_a: assert property (pin_sync[1] == pin_sync[2]
      |=> pin_level == $past(pin_sync[2]))
      else $error("pin level did not follow agreeing stages");

   // Same routing checks for every sequencer, so a slip in one field's slice shows up
   genvar k;
   generate
      for (k = 0; k < atss_pkg::ATSS_NUM_SEQ; k++) begin : g_chk
         soft_route_a: assert property (trig_sel[4*k+3:4*k] == atss_pkg::ATSS_CODE_SOFTWARE
            |=> SEQ_START[k] == $past(SOFTWARE_REQUEST[k]))
            else $error("software request not routed");
         comp_route_a: assert property (trig_sel[4*k+3:4*k] == atss_pkg::ATSS_CODE_COMPARATOR
            |=> SEQ_START[k] == $past(COMPARATOR0_EVENT))
            else $error("comparator event not routed");
         pin_route_a: assert property (trig_sel[4*k+3:4*k] == atss_pkg::ATSS_CODE_EXTERNAL
            |=> SEQ_START[k] == $past(pin_level))
            else $error("pin event not routed");
         timer_route_a: assert property (trig_sel[4*k+3:4*k] == atss_pkg::ATSS_CODE_TIMER
            |=> SEQ_START[k] == $past(TIMER_EVENT && TIMER_ADC_TRIGGER_ENABLE))
            else $error("timer event not gated by its enable");
         always_route_a: assert property (trig_sel[4*k+3:4*k] == atss_pkg::ATSS_CODE_ALWAYS
            |=> SEQ_START[k])
            else $error("continuous mode did not start");
         reserved_route_a: assert property (trig_sel[4*k+3:4*k] inside {4'h2, 4'h3, [4'h6:4'he]}
            |=> !SEQ_START[k])
            else $error("reserved code produced a trigger");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Scenario covers
   // ----------------------------------------------------------------
   timer_fire_c: cover property (trig_sel[11:8] == 4'h5 && TIMER_EVENT && TIMER_ADC_TRIGGER_ENABLE ##1 SEQ_START[2]);
   pin_fire_c: cover property (trig_sel[3:0] == 4'h4 ##1 pin_level ##1 SEQ_START[0]);
   comp_fire_c: cover property (trig_sel[7:4] == 4'h1 && COMPARATOR0_EVENT ##1 SEQ_START[1]);
   write_c: cover property (wr_en && PSTRB == 4'hf);
   unmapped_c: cover property (PSEL && PENABLE && PWRITE && !hit);
endmodule

// ### verif/atss_trigger_select_tb.sv
// Testbench for the converter trigger-source selector and its APB register.
// Assumes the package and the selector module are compiled before this file.
`timescale 1ns/100ps
module atss_trigger_select_tb;
   localparam logic [11:0] off = atss_pkg::ATSS_TRIG_SEL_OFFSET;
   logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic comp = 1'b1, pin = 1'b1, tev = 1'b1, ten = 1'b1, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] sw = 4'hf, seq_start;
   logic [15:0] sel;
   int err_count = 0, n_tests = 0;
   atss_trigger_select i_atss_trigger_select (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SOFTWARE_REQUEST(sw), .COMPARATOR0_EVENT(comp), .EXTERNAL_TRIGGER_PIN(pin),
      .TIMER_EVENT(tev), .TIMER_ADC_TRIGGER_ENABLE(ten), .SEQ_START(seq_start), .SEQUENCER_TRIGGER_SELECT(sel));
   always #10 mclk = ~mclk;
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pin path needs a few cycles of synchroniser, so six cycles cover every source
   task automatic trig(input logic [3:0] c, input logic [3:0] exp);
      apb(1'b1, off, {16'h0, {4{c}}});
      repeat (6) @(posedge mclk);
      chk("select", {16'h0, {4{c}}}, {16'h0, sel});
      chk("start", {28'h0, exp}, {28'h0, seq_start});
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      #50us;
      err_count++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      apb(1'b0, off, 32'h0);
      chk("reset value", 32'h0, rd);
      for (int c = 0; c < 16; c++) begin
         trig(4'(c), (c == 0 || c == 1 || c == 4 || c == 5 || c == 15) ? 4'hf : 4'h0);
      end
      ten <= 1'b0;
      trig(4'h5, 4'h0);
      apb(1'b1, off, 32'hffff_5f21);
      apb(1'b0, off, 32'h0);
      chk("readback", 32'h0000_5f21, rd);
      repeat (4) @(posedge mclk);
      chk("mixed start", 32'h5, {28'h0, seq_start});
      apb(1'b1, 12'h018, 32'h0000_ffff);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped read", 32'h0, rd);
      comp <= 1'b0;
      apb(1'b0, off, 32'h0);
      chk("after unmapped", 32'h0000_5f21, rd);
      repeat (3) @(posedge mclk);
      chk("comparator low", 32'h4, {28'h0, seq_start});
      sw <= 4'h5;
      apb(1'b1, off, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      chk("software per sequencer", 32'h5, {28'h0, seq_start});
      pin <= 1'b0;
      apb(1'b1, off, 32'h0000_4444);
      repeat (6) @(posedge mclk);
      chk("pin low", 32'h0, {28'h0, seq_start});
      close_out();
   end
endmodule
